// ### twcs_top.sv
// two-wire control/status block with a compact byte engine behind it
// assumes apb master on CLK, external open-drain resolution of bus lines
// Contract
// - rate from control bits 7,1,0; master only
// - divisions 256,224,192,160,-,120,60,96xtimer1
// - bit 6 enables the interface
// - bit 5 requests start; software clears
// - bit 4 requests stop; hardware clears
// - hardware sets pending flag; software clears
// - pending flag holds clock line low
// - clearing pending launches next operation
// - ack bit drives ack/nack when receiving
// - ack bit enables own/broadcast address recognition
// - ack bit ignored as master transmitter
// - status code in bits 7..3, low zero
// - status updated one cycle after pending
// - broadcast enable matches address 00h
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
module twcs_top (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic TIMER1_OVF,
  input wire logic SCL_IN,
  output logic SCL_OUT,
  output logic SCL_OE,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  output logic IRQ
);
  typedef enum {ST_IDLE, ST_START, ST_BIT_LO, ST_BIT_HI, ST_STOP,
    ST_WAIT} twcs_state_e;

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  function automatic logic [8:0] twcs_div(input logic [2:0] code);
    logic [8:0] d;
    d = twcs_pkg::DIV_0;
    unique case (code)
      3'h0: d = twcs_pkg::DIV_0;
      3'h1: d = twcs_pkg::DIV_1;
      3'h2: d = twcs_pkg::DIV_2;
      3'h3: d = twcs_pkg::DIV_3;
      3'h4: d = twcs_pkg::DIV_0; // unused code, keep a safe rate
      3'h5: d = twcs_pkg::DIV_5;
      3'h6: d = twcs_pkg::DIV_6;
      3'h7: d = twcs_pkg::DIV_TMR;
    endcase
    return d;
  endfunction : twcs_div

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] scl_sync_reg, sda_sync_reg, ovf_sync_reg;
  logic scl_s_reg, sda_s_reg, ovf_s_reg;
  // two flops, then a third stage readable by logic for edges
  always_ff @(posedge CLK) begin
    if (RESET) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      ovf_sync_reg <= 2'h0;
      scl_s_reg <= 1'b1;
      sda_s_reg <= 1'b1;
      ovf_s_reg <= 1'b0;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], SCL_IN};
      sda_sync_reg <= {sda_sync_reg[0], SDA_IN};
      ovf_sync_reg <= {ovf_sync_reg[0], TIMER1_OVF};
      scl_s_reg <= scl_sync_reg[1];
      sda_s_reg <= sda_sync_reg[1];
      ovf_s_reg <= ovf_sync_reg[1];
    end
  end
  logic scl_l, sda_l, scl_rise, scl_fall, bus_start, bus_stop, ovf_tick;
  assign scl_l = scl_sync_reg[1];
  assign sda_l = sda_sync_reg[1];
  assign scl_rise = scl_l & ~scl_s_reg;
  assign scl_fall = ~scl_l & scl_s_reg;
  assign bus_start = scl_l & scl_s_reg & ~sda_l & sda_s_reg;
  assign bus_stop = scl_l & scl_s_reg & sda_l & ~sda_s_reg;
  assign ovf_tick = ovf_sync_reg[1] & ~ovf_s_reg;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [7:0] ctl_reg, ctl_next, adr_reg, adr_next, dat_reg, dat_next;
  logic [4:0] code_reg, code_next, evt_reg, evt_next;
  logic [1:0] ist_reg, ist_next, imask_reg, imask_next;
  twcs_state_e st_reg, st_next;
  logic [8:0] cnt_reg, cnt_next;
  logic [3:0] bit_reg, bit_next;
  logic master_reg, master_next, tx_reg, tx_next, slave_reg, slave_next;
  logic sda_o_reg, sda_o_next, scl_o_reg, scl_o_next;
  logic adr_seen_reg, adr_seen_next, busy_reg, busy_next;

  logic acc, wr, hit_ctl, pend, en, tick, set_pend;
  logic [7:0] idx;
  logic [4:0] set_code;
  assign acc = PSEL & PENABLE;
  assign wr = acc & PWRITE;
  assign idx = PADDR[9:2];
  assign pend = ctl_reg[twcs_pkg::B_PEND];
  assign en = ctl_reg[twcs_pkg::B_ENABLE];
  // timer code counts synced overflows, others count CLK
  assign tick = (ctl_reg[twcs_pkg::B_RATE_HI] &
    ctl_reg[twcs_pkg::B_RATE_MID] & ctl_reg[twcs_pkg::B_RATE_LO]) ?
    ovf_tick : 1'b1;

  // ------------------------------------------------------------
  // byte engine next state
  // ------------------------------------------------------------
  always_comb begin
    logic [8:0] div;
    logic [8:0] half;
    div = twcs_div({ctl_reg[twcs_pkg::B_RATE_HI],
      ctl_reg[twcs_pkg::B_RATE_MID], ctl_reg[twcs_pkg::B_RATE_LO]});
    // counter runs down to zero inclusive, so load one below half
    half = {1'b0, div[8:1]} - 9'h001;
    st_next = st_reg;
    cnt_next = cnt_reg;
    bit_next = bit_reg;
    master_next = master_reg;
    tx_next = tx_reg;
    slave_next = slave_reg;
    sda_o_next = sda_o_reg;
    scl_o_next = scl_o_reg;
    busy_next = busy_reg;
    adr_seen_next = adr_seen_reg;
    set_pend = 1'b0;
    set_code = evt_reg;
    dat_next = dat_reg;
    if (bus_start) busy_next = 1'b1;
    if (bus_stop) busy_next = 1'b0;
    if (!en) begin
      st_next = ST_IDLE;
      master_next = 1'b0;
      slave_next = 1'b0;
      sda_o_next = 1'b1;
      scl_o_next = 1'b1;
    end else if (!master_reg && st_reg == ST_IDLE) begin
      // slave path: shift bits on rising scl after a start
      if (bus_start) begin
        bit_next = 4'h0;
        slave_next = ctl_reg[twcs_pkg::B_ACK];
        adr_seen_next = 1'b0;
        tx_next = 1'b0;
      end else if (bus_stop && slave_reg) begin
        slave_next = 1'b0;
        set_pend = 1'b1;
        set_code = twcs_pkg::SC_SL_STOP;
      end else if (slave_reg && scl_rise && !pend && bit_reg < 4'h8)
        begin
        dat_next = {dat_reg[6:0], sda_l};
        bit_next = bit_reg + 4'h1;
      end else if (slave_reg && scl_fall && bit_reg == 4'h9 && !pend)
        begin
        sda_o_next = 1'b1; // ack slot over, let the line go
        bit_next = 4'h0;
      end else if (slave_reg && scl_fall && bit_reg == 4'h8 && !pend)
        begin
        bit_next = 4'h9;
        if (adr_seen_reg) begin
          sda_o_next = ~ctl_reg[twcs_pkg::B_ACK];
          set_pend = 1'b1;
          set_code = twcs_pkg::SC_SL_DATA;
        end else if (dat_reg[7:1] == adr_reg[7:1] ||
          (adr_reg[0] && dat_reg == twcs_pkg::BROADCAST_ADDR)) begin
          sda_o_next = 1'b0;
          set_pend = 1'b1;
          set_code = twcs_pkg::SC_SL_ADDR;
          tx_next = dat_reg[0];
          adr_seen_next = 1'b1;
        end else begin
          slave_next = 1'b0;
        end
      end
      if (!pend && !busy_reg && ctl_reg[twcs_pkg::B_BEGIN]) begin
        st_next = ST_START;
        master_next = 1'b1;
        cnt_next = half;
      end
    end else if (master_reg && tick) begin
      if (cnt_reg != 9'h000) cnt_next = cnt_reg - 9'h001;
      unique case (st_reg)
        ST_IDLE: st_next = ST_WAIT;
        // data falls while clock is high, then clock falls
        ST_START: if (cnt_reg == 9'h000) begin
          cnt_next = half;
          if (!scl_o_reg) begin
            scl_o_next = 1'b1;
          end else if (sda_o_reg) begin
            sda_o_next = 1'b0;
          end else begin
            scl_o_next = 1'b0;
            set_pend = 1'b1;
            set_code = twcs_pkg::SC_START;
            tx_next = 1'b1;
            bit_next = 4'h0;
            st_next = ST_WAIT;
          end
        end
        ST_WAIT: if (!pend) begin
          cnt_next = half;
          if (ctl_reg[twcs_pkg::B_HALT]) begin
            sda_o_next = 1'b0;
            st_next = ST_STOP;
          end else if (ctl_reg[twcs_pkg::B_BEGIN]) begin
            sda_o_next = 1'b1;
            st_next = ST_START;
          end else begin
            bit_next = 4'h0;
            st_next = ST_BIT_LO;
          end
        end
        ST_BIT_LO: if (cnt_reg == 9'h000) begin
          if (bit_reg < 4'h8)
            sda_o_next = tx_reg ? dat_reg[3'h7 - bit_reg[2:0]] : 1'b1;
          else // acknowledge slot; ack bit unused as transmitter
            sda_o_next = tx_reg ? 1'b1 :
              ~ctl_reg[twcs_pkg::B_ACK];
          scl_o_next = 1'b1;
          cnt_next = half;
          st_next = ST_BIT_HI;
        end
        ST_BIT_HI: if (cnt_reg == 9'h000 && scl_l) begin
          scl_o_next = 1'b0;
          cnt_next = half;
          if (sda_o_reg && !sda_l) begin
            master_next = 1'b0;
            set_pend = 1'b1;
            set_code = twcs_pkg::SC_ARB_LOST;
            st_next = ST_IDLE;
          end else if (bit_reg == 4'h8) begin
            set_pend = 1'b1;
            set_code = tx_reg ? (sda_l ? twcs_pkg::SC_MT_NACK :
              twcs_pkg::SC_MT_ACK) : (sda_o_reg ? twcs_pkg::SC_MR_NACK
              : twcs_pkg::SC_MR_DATA);
            st_next = ST_WAIT;
          end else begin
            if (!tx_reg) dat_next = {dat_reg[6:0], sda_l};
            bit_next = bit_reg + 4'h1;
            st_next = ST_BIT_LO;
          end
        end
        ST_STOP: if (cnt_reg == 9'h000) begin
          if (!scl_o_reg) begin
            scl_o_next = 1'b1;
            cnt_next = half;
          end else begin
            sda_o_next = 1'b1; // stop placed on the bus
            master_next = 1'b0;
            st_next = ST_IDLE;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // register file next values
  // ------------------------------------------------------------
  logic stop_done;
  assign stop_done = st_reg == ST_STOP && st_next == ST_IDLE;
  always_comb begin
    ctl_next = ctl_reg;
    adr_next = adr_reg;
    imask_next = imask_reg;
    ist_next = ist_reg;
    evt_next = set_pend ? set_code : evt_reg;
    if (wr && idx == twcs_pkg::IDX_CONTROL) ctl_next = PWDATA[7:0];
    if (wr && idx == twcs_pkg::IDX_ADDRESS) adr_next = PWDATA[7:0];
    if (wr && idx == twcs_pkg::IDX_IRQ_MASK) imask_next = PWDATA[1:0];
    if (wr && idx == twcs_pkg::IDX_IRQ_STAT)
      ist_next = ist_reg & ~PWDATA[1:0];
    if (stop_done) ctl_next[twcs_pkg::B_HALT] = 1'b0;
    if (set_pend) begin // set wins over a clearing write
      ctl_next[twcs_pkg::B_PEND] = 1'b1;
      ist_next[0] = 1'b1;
    end
    if (stop_done) ist_next[1] = 1'b1;
    // status follows the flag one cycle later
    code_next = pend ? evt_reg : twcs_pkg::SC_NONE;
  end
  // data register: software writes only while pending is set
  logic [7:0] dat_sel;
  assign dat_sel = (wr && idx == twcs_pkg::IDX_DATA && pend) ?
    PWDATA[7:0] : dat_next;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ctl_reg <= twcs_pkg::RST_CONTROL;
      adr_reg <= twcs_pkg::RST_ADDRESS;
      dat_reg <= twcs_pkg::RST_DATA;
      code_reg <= twcs_pkg::SC_NONE;
      evt_reg <= twcs_pkg::SC_NONE;
      ist_reg <= 2'h0;
      imask_reg <= 2'h0;
      st_reg <= ST_IDLE;
      cnt_reg <= 9'h000;
      bit_reg <= 4'h0;
      master_reg <= 1'b0;
      tx_reg <= 1'b0;
      slave_reg <= 1'b0;
      sda_o_reg <= 1'b1;
      scl_o_reg <= 1'b1;
      adr_seen_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      ctl_reg <= ctl_next;
      adr_reg <= adr_next;
      dat_reg <= dat_sel;
      code_reg <= code_next;
      evt_reg <= evt_next;
      ist_reg <= ist_next;
      imask_reg <= imask_next;
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      master_reg <= master_next;
      tx_reg <= tx_next;
      slave_reg <= slave_next;
      sda_o_reg <= sda_o_next;
      scl_o_reg <= scl_o_next;
      adr_seen_reg <= adr_seen_next;
      busy_reg <= busy_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // read mux; unmapped indexes read zero with no error
  always_comb begin
    PRDATA = 32'h0000_0000;
    unique case (idx)
      twcs_pkg::IDX_CONTROL: PRDATA[7:0] = ctl_reg;
      twcs_pkg::IDX_STATUS: PRDATA[7:0] = {code_reg, 3'h0};
      twcs_pkg::IDX_ADDRESS: PRDATA[7:0] = adr_reg;
      twcs_pkg::IDX_DATA: PRDATA[7:0] = dat_reg;
      twcs_pkg::IDX_IRQ_STAT: PRDATA[1:0] = ist_reg;
      twcs_pkg::IDX_IRQ_MASK: PRDATA[1:0] = imask_reg;
      default: PRDATA = 32'h0000_0000;
    endcase
  end
  assign PREADY = 1'b1;
  assign PSLVERR = 1'b0;
  assign IRQ = |(ist_reg & imask_reg);
  // pending stretches clock low; disabled interface floats both lines
  assign SCL_OUT = 1'b0;
  assign SCL_OE = en & (~scl_o_reg | pend);
  assign SDA_OUT = 1'b0;
  assign SDA_OE = en & ~sda_o_reg;
endmodule : twcs_top

// ### twcs_pkg.sv
// package for the two-wire control and status block
// assumes an apb slave on CLK and open-drain bus pins handled outside
package twcs_pkg;
  // ------------------------------------------------------------
  // register map (offsets 0xAA/0xAB are indexes; byte = 4*index)
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_CONTROL = 8'hAA;
  localparam logic [7:0] IDX_STATUS = 8'hAB;
  localparam logic [7:0] IDX_ADDRESS = 8'hAC;
  localparam logic [7:0] IDX_DATA = 8'hAD;
  localparam logic [7:0] IDX_IRQ_STAT = 8'hB0;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hB1;
  localparam logic [7:0] IDX_TIMER1 = 8'hB2;
  // ------------------------------------------------------------
  // control register fields
  // ------------------------------------------------------------
  localparam int B_RATE_HI = 7;
  localparam int B_ENABLE = 6;
  localparam int B_BEGIN = 5;
  localparam int B_HALT = 4;
  localparam int B_PEND = 3;
  localparam int B_ACK = 2;
  localparam int B_RATE_MID = 1;
  localparam int B_RATE_LO = 0;
  // ------------------------------------------------------------
  // reset values and status codes
  // ------------------------------------------------------------
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_ADDRESS = 8'hFE;
  localparam logic [7:0] RST_DATA = 8'hFF;
  localparam logic [4:0] SC_NONE = 5'h1F;
  localparam logic [4:0] SC_START = 5'h01;
  localparam logic [4:0] SC_RSTART = 5'h02;
  localparam logic [4:0] SC_MT_ACK = 5'h03;
  localparam logic [4:0] SC_MT_NACK = 5'h04;
  localparam logic [4:0] SC_MR_DATA = 5'h0A;
  localparam logic [4:0] SC_MR_NACK = 5'h0B;
  localparam logic [4:0] SC_SL_ADDR = 5'h0C;
  localparam logic [4:0] SC_SL_DATA = 5'h10;
  localparam logic [4:0] SC_SL_STOP = 5'h14;
  localparam logic [4:0] SC_ST_DATA = 5'h15;
  localparam logic [4:0] SC_ARB_LOST = 5'h07;
  localparam logic [7:0] BROADCAST_ADDR = 8'h00;
  // oscillator divisions per rate code; code 4 has no entry, TMR marks timer
  localparam logic [8:0] DIV_0 = 9'h100;
  localparam logic [8:0] DIV_1 = 9'h0E0;
  localparam logic [8:0] DIV_2 = 9'h0C0;
  localparam logic [8:0] DIV_3 = 9'h0A0;
  localparam logic [8:0] DIV_5 = 9'h078;
  localparam logic [8:0] DIV_6 = 9'h03C;
  localparam logic [8:0] DIV_TMR = 9'h060;
  localparam logic [3:0] SAMPLE_HOLD = 4'h2;
endpackage : twcs_pkg

// ### twcs_monitor.sv
// checker for the two-wire control/status block, top ports only
// assumes it is bound onto twcs_top and sees a zero-wait apb slave
`timescale 1ns/1ps
module twcs_monitor (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic TIMER1_OVF,
  input wire logic SCL_IN,
  input wire logic SCL_OUT,
  input wire logic SCL_OE,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic IRQ
);
  // ------------------------------------------------------------
  // access phases and properties
  // ------------------------------------------------------------
  logic [7:0] idx;
  assign idx = PADDR[9:2];
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  // read access phase of one register index
  sequence rd_at(logic [7:0] i);
    PSEL && PENABLE && !PWRITE && idx == i;
  endsequence
  // control write with the enable bit low, setup then access
  sequence off_wr;
    PSEL && !PENABLE && PWRITE && idx == twcs_pkg::IDX_CONTROL &&
      !PWDATA[twcs_pkg::B_ENABLE] ##1 PSEL && PENABLE;
  endsequence
  zero_wait_a: assert property (PSEL && PENABLE |-> PREADY && !PSLVERR)
    else $error("apb access stalled or errored");
  upper_zero_a: assert property (PSEL && PENABLE && !PWRITE |->
    PRDATA[31:8] == 24'h0) else $error("upper read bits not zero");
  status_low_a: assert property (rd_at(twcs_pkg::IDX_STATUS) |->
    PRDATA[2:0] == 3'h0) else $error("status low bits not zero");
  pend_stretch_a: assert property (rd_at(twcs_pkg::IDX_CONTROL) ##0
    PRDATA[twcs_pkg::B_PEND] |-> SCL_OE) else $error("clock not held");
  disable_release_a: assert property (off_wr |->
    ##[1:4] (!SCL_OE && !SDA_OE)) else $error("lines kept when disabled");
  reset_quiet_a: assert property ($fell(RESET) |->
    !IRQ && !SCL_OE && !SDA_OE) else $error("outputs active after reset");
  open_drain_a: assert property (!SCL_OUT && !SDA_OUT)
    else $error("line driven high");
  irq_level_a: assert property (rd_at(twcs_pkg::IDX_IRQ_STAT) ##0
    PRDATA[1:0] == 2'h0 |-> !IRQ) else $error("irq without event");
endmodule : twcs_monitor

bind twcs_top twcs_monitor u_mon (.CLK(CLK), .RESET(RESET), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .TIMER1_OVF(TIMER1_OVF), .SCL_IN(SCL_IN), .SCL_OUT(SCL_OUT),
  .SCL_OE(SCL_OE), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
  .IRQ(IRQ));

// ### twcs_peer.sv
// two-wire master model on the far side of the pins
// assumes the bench resolves both lines as wired-and with pull-ups
`timescale 1ns/1ps
module twcs_peer (
  output logic scl_oe,
  output logic sda_oe,
  input wire logic scl,
  input wire logic sda
);
  // ------------------------------------------------------------
  // bit and frame generation, 320 ns per bit
  // ------------------------------------------------------------
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  // waits out any low stretch, so a held clock never loses a bit
  task automatic put_bit(input logic b, output logic seen);
    sda_oe = ~b;
    #80;
    scl_oe = 1'b0;
    wait (scl === 1'b1);
    #80;
    seen = sda;
    #80;
    scl_oe = 1'b1;
    #80;
  endtask : put_bit
  // start, address byte, data byte only if taken, stop
  task automatic frame(input logic [7:0] a, input logic [7:0] d,
                       output logic a_ack, output logic d_ack);
    logic s;
    #10; // keep line changes away from the sampling edge
    d_ack = 1'b0;
    sda_oe = 1'b1;
    #160;
    scl_oe = 1'b1;
    for (int i = 7; i >= 0; i--) put_bit(a[i], s);
    put_bit(1'b1, s);
    a_ack = ~s;
    if (a_ack) begin
      for (int i = 7; i >= 0; i--) put_bit(d[i], s);
      put_bit(1'b1, s);
      d_ack = ~s;
    end
    sda_oe = 1'b1;
    #80;
    scl_oe = 1'b0;
    wait (scl === 1'b1);
    #80;
    sda_oe = 1'b0; // data rises while clock is high
    #160;
  endtask : frame
endmodule : twcs_peer

// ### twcs_bench.sv
// self-checking bench for the two-wire control/status block
// assumes twcs_top, twcs_peer and the bound checker compile first
`timescale 1ns/1ps
module twcs_bench;
  // ------------------------------------------------------------
  // stimulus, model tables and checks
  // ------------------------------------------------------------
  logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, tmr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, scl_oe, scl_out, sda_oe, sda_out, irq;
  logic p_scl_oe, p_sda_oe, a_ack, d_ack;
  logic [7:0] v, byt, own;
  int failures = 0, compares = 0, seed = 32'h6138, per;
  // master clock periods per rate code, in CLK cycles; code 7 runs
  // off a timer overflow every 2 cycles
  int divs[8] = '{256, 224, 192, 160, 256, 120, 60, 192};
  wire scl = ~(scl_oe | p_scl_oe);
  wire sda = ~(sda_oe | p_sda_oe);
  always #20 clk = ~clk;
  always @(posedge clk) tmr <= ~tmr;
  twcs_top uut (.CLK(clk), .RESET(reset), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .TIMER1_OVF(tmr), .SCL_IN(scl),
    .SCL_OUT(scl_out), .SCL_OE(scl_oe), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .IRQ(irq));
  twcs_peer peer (.scl_oe(p_scl_oe), .sda_oe(p_sda_oe), .scl(scl),
    .sda(sda));
  task automatic close_out;
    if (failures == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] i,
                     input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rdc(input string n, input logic [7:0] i,
                     input logic [31:0] e);
    apb(1'b0, i, 8'h00);
    chk(n, e, rd);
  endtask : rdc
  function automatic logic [31:0] sc(input logic [4:0] s);
    return {24'h0, s, 3'h0};
  endfunction : sc
  // polls one control bit; bounded so a lost event shows as a mismatch
  task automatic wait_ctrl(input int b, input logic lvl);
    int n = 0;
    do begin
      apb(1'b0, twcs_pkg::IDX_CONTROL, 8'h00);
      n++;
    end while (rd[b] !== lvl && n < 3000);
    chk("control bit", {31'h0, lvl}, {31'h0, rd[b]});
  endtask : wait_ctrl
  initial begin
    #2000000;
    failures++;
    close_out();
  end
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rdc("control", twcs_pkg::IDX_CONTROL, 32'h0);
    rdc("status", twcs_pkg::IDX_STATUS, 32'hF8);
    rdc("address", twcs_pkg::IDX_ADDRESS, 32'hFE);
    apb(1'b1, twcs_pkg::IDX_DATA, 8'h5A);
    rdc("data", twcs_pkg::IDX_DATA, 32'hFF);
    rdc("unmapped", 8'h3C, 32'h0);
    v = 8'($random(seed)) & 8'hA7;
    apb(1'b1, twcs_pkg::IDX_CONTROL, v);
    rdc("control", twcs_pkg::IDX_CONTROL, {24'h0, v});
    chk("idle drive", 32'h0, {31'h0, scl_oe | sda_oe});
    apb(1'b1, twcs_pkg::IDX_IRQ_MASK, 8'h00);
    // master start, address with nobody answering, stop; every rate
    for (int c = 0; c < 8; c++) begin
      v = {c[2], 5'b11000, c[1:0]};
      v[2] = 1'($random(seed));
      byt = {2'b01, 5'($random(seed)), 1'b0};
      apb(1'b1, twcs_pkg::IDX_CONTROL, v);
      wait_ctrl(twcs_pkg::B_PEND, 1'b1);
      rdc("start code", twcs_pkg::IDX_STATUS, sc(twcs_pkg::SC_START));
      if (c == 0) begin
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, twcs_pkg::IDX_IRQ_MASK, 8'h01);
        chk("irq", 32'h1, {31'h0, irq});
        apb(1'b1, twcs_pkg::IDX_IRQ_STAT, 8'h01);
        chk("irq cleared", 32'h0, {31'h0, irq});
        rdc("irq status", twcs_pkg::IDX_IRQ_STAT, 32'h0);
      end
      apb(1'b1, twcs_pkg::IDX_DATA, byt);
      rdc("data", twcs_pkg::IDX_DATA, {24'h0, byt});
      apb(1'b1, twcs_pkg::IDX_CONTROL, v & 8'hC7);
      @(posedge scl);
      @(posedge scl);
      per = int'($time);
      @(posedge scl);
      per = (int'($time) - per) / 40;
      chk("scl period", divs[c], per);
      wait_ctrl(twcs_pkg::B_PEND, 1'b1);
      rdc("nack code", twcs_pkg::IDX_STATUS, sc(twcs_pkg::SC_MT_NACK));
      apb(1'b1, twcs_pkg::IDX_CONTROL, (v & 8'hC7) | 8'h10);
      wait_ctrl(twcs_pkg::B_HALT, 1'b0);
      chk("bus idle", 32'h1, {31'h0, scl & sda});
    end
    // slave: own address, refused with ack off, broadcast on and off
    for (int k = 0; k < 4; k++) begin
      own = {7'($random(seed)) | 7'h01, k == 2};
      byt = (k < 2) ? {own[7:1], 1'b0} : twcs_pkg::BROADCAST_ADDR;
      v = 8'($random(seed));
      apb(1'b1, twcs_pkg::IDX_ADDRESS, own);
      apb(1'b1, twcs_pkg::IDX_CONTROL, {5'b01000, k != 1, 2'b00});
      fork
        peer.frame(byt, v, a_ack, d_ack);
        if (k == 0 || k == 2) begin
          wait_ctrl(twcs_pkg::B_PEND, 1'b1);
          rdc("addr code", twcs_pkg::IDX_STATUS, sc(twcs_pkg::SC_SL_ADDR));
          chk("stretch", 32'h1, {31'h0, scl_oe});
          apb(1'b1, twcs_pkg::IDX_CONTROL, 8'h44);
          wait_ctrl(twcs_pkg::B_PEND, 1'b1);
          rdc("slave data", twcs_pkg::IDX_DATA, {24'h0, v});
          apb(1'b1, twcs_pkg::IDX_CONTROL, 8'h44);
        end
      join
      chk("addr ack", {31'h0, k == 0 || k == 2}, {31'h0, a_ack});
      chk("data ack", {31'h0, k == 0 || k == 2}, {31'h0, d_ack});
      apb(1'b1, twcs_pkg::IDX_CONTROL, 8'h44);
    end
    apb(1'b1, twcs_pkg::IDX_CONTROL, 8'h00);
    close_out();
  end
endmodule : twcs_bench
